//--- vfl_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the frequency limiter and volts-per-hertz curve block.
// Assumes a 10 MHz core clock and a 32-bit APB register port.
`ifndef VFL_REGS_SVH
`define VFL_REGS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define VFL_OFF_FMAX   8'h00
`define VFL_OFF_FBASE  8'h04
`define VFL_OFF_VMAX   8'h08
`define VFL_OFF_FMID   8'h0c
`define VFL_OFF_VMID   8'h10
`define VFL_OFF_FMIN   8'h14
`define VFL_OFF_VMIN   8'h18
`define VFL_OFF_UPPCT  8'h1c
`define VFL_OFF_LOPCT  8'h20
`define VFL_OFF_CTRL   8'h24
`define VFL_OFF_DCMD   8'h28
`define VFL_OFF_STAT   8'h2c
`define VFL_OFF_FOUT   8'h30
`define VFL_OFF_VOUT   8'h34
`define VFL_OFF_TIME0  8'h40
`define VFL_OFF_TIME7  8'h5c
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define VFL_CTRL_METH_LSB 0
`define VFL_CTRL_FSEL_LSB 4
`define VFL_CTRL_SRC_LSB  8
// ----------------------------------------------------------------
// Ranges and reset values (0.01 Hz, 0.1 V, percent, 0.1 s)
// ----------------------------------------------------------------
`define VFL_FMAX_MIN   16'd5000
`define VFL_FMAX_MAX   16'd40000
`define VFL_FMAX_RST   16'd6000
`define VFL_F_MIN      16'd10
`define VFL_F_MAX      16'd40000
`define VFL_FBASE_RST  16'd6000
`define VFL_FMID_RST   16'd50
`define VFL_FMIN_RST   16'd50
`define VFL_V_MIN      16'd1
`define VFL_UP_MIN     16'd1
`define VFL_UP_MAX     16'd120
`define VFL_UP_RST     16'd100
`define VFL_LO_MAX     16'd100
`define VFL_LO_RST     16'd0
`define VFL_T_MIN      16'd1
`define VFL_T_MAX      16'd36000
`define VFL_T_RST      16'd100
`define VFL_PCT_DIV    32'd100
// ----------------------------------------------------------------
// Analog command scaling (12-bit converter codes)
// ----------------------------------------------------------------
`define VFL_ADC_FULL   32'd4095
`define VFL_CUR_4MA    12'd819
`define VFL_CUR_SPAN   32'd3276
`define VFL_BIP_OFS    12'h800
// ----------------------------------------------------------------
// Timing: ramp time unit 0.1 s at a 100 ns clock
// ----------------------------------------------------------------
`define VFL_CLK_PERIOD_NS 36'd100
`define VFL_TIME_UNIT_NS  36'd100000000
`define VFL_CYC_PER_UNIT  (`VFL_TIME_UNIT_NS / `VFL_CLK_PERIOD_NS)
`endif

//--- vfl_pkg.sv
// Types shared by the limiter top and its time-setting store.
// Assumes the constants of vfl_regs.svh.
package vfl_pkg;
   typedef enum logic [2:0] {
      VFL_HOLD  = 3'b001,
      VFL_ACCEL = 3'b010,
      VFL_DECEL = 3'b100
   } vfl_ramp_t;
   typedef enum logic [1:0] {
      VFL_SRC_DIG = 2'h0,
      VFL_SRC_UNI = 2'h1,
      VFL_SRC_CUR = 2'h2,
      VFL_SRC_BIP = 2'h3
   } vfl_src_t;
   typedef logic [15:0] vfl_word_t;
endpackage : vfl_pkg

//--- vfl_mem_if.sv
// Carrier between the limiter top and its ramp-time store.
// Assumes one clock; the store answers reads one cycle later.
`timescale 1ns/1ps
interface vfl_mem_if;
   logic             wrEn;
   logic [2:0]       wrAddr;
   vfl_pkg::vfl_word_t wrData;
   logic [2:0]       rdAddrA;
   vfl_pkg::vfl_word_t rdDataA;
   logic [2:0]       rdAddrB;
   vfl_pkg::vfl_word_t rdDataB;
   modport ctrl (output wrEn, wrAddr, wrData, rdAddrA, rdAddrB,
                 input rdDataA, rdDataB);
   modport mem  (input wrEn, wrAddr, wrData, rdAddrA, rdAddrB,
                 output rdDataA, rdDataB);
endinterface : vfl_mem_if

//--- vfl_time_mem.sv
// Eight ramp-time words: accel and decel for four time sets.
// Assumes writes are already range checked; reads are registered.
`timescale 1ns/1ps
`include "vfl_regs.svh"
module vfl_time_mem (
   input wire logic core_clk,
   input wire logic rst,
   vfl_mem_if.mem   bus
);
   import vfl_pkg::*;
   vfl_word_t timeMem_q [8];

   // ----------------------------------------------------------------
   // Storage, reset to the default ramp time
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            timeMem_q[i] <= `VFL_T_RST;
         end
      end else if (bus.wrEn) begin
         timeMem_q[bus.wrAddr] <= bus.wrData;
      end
   end

   // Both read ports registered so that data leave a flip-flop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus.rdDataA <= 16'h0000;
         bus.rdDataB <= 16'h0000;
      end else begin
         bus.rdDataA <= timeMem_q[bus.rdAddrA];
         bus.rdDataB <= timeMem_q[bus.rdAddrB];
      end
   end
endmodule : vfl_time_mem

//--- vfl_limiter.sv
// Frequency command limiter, ramp and volts-per-hertz curve.
// Assumes an APB master on core_clk and converter codes from pins.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "vfl_regs.svh"

module vfl_limiter #(
   parameter int VOLT_SERIES = 0
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic              pready,
   output logic              pslverr,
   output logic [31:0]       prdata,
   input  wire logic [11:0]  adcUni,
   input  wire logic [11:0]  adcCur,
   input  wire logic [11:0]  adcBip,
   input  wire logic [1:0]   accelSel,
   input  wire logic         encoderCardPresent,
   output vfl_pkg::vfl_word_t freqOut,
   output vfl_pkg::vfl_word_t voltOut,
   output logic              vectorMode,
   output logic              encoderFeedbackEn
);
   import vfl_pkg::*;

   // ----------------------------------------------------------------
   // Series-dependent limits and defaults
   // ----------------------------------------------------------------
   localparam vfl_word_t VLIM = (VOLT_SERIES == 2) ? 16'd6370 :
                                (VOLT_SERIES == 1) ? 16'd5100 : 16'd2550;
   localparam vfl_word_t VMAX_RST = (VOLT_SERIES == 2) ? 16'd5750 :
                                    (VOLT_SERIES == 1) ? 16'd4400 : 16'd2200;
   localparam vfl_word_t VLOW_RST = (VOLT_SERIES == 2) ? 16'd48 :
                                    (VOLT_SERIES == 1) ? 16'd34 : 16'd17;

   function automatic vfl_word_t clampw(input logic [31:0] v,
                                        input vfl_word_t lo, input vfl_word_t hi);
      if (v < 32'(lo)) return lo;
      if (v > 32'(hi)) return hi;
      return v[15:0];
   endfunction : clampw

   function automatic vfl_word_t minw(input vfl_word_t a, input vfl_word_t b);
      return (a < b) ? a : b;
   endfunction : minw

   // Linear interpolation; callers keep v1 >= v0 and f1 > f0
   function automatic vfl_word_t lerp(input vfl_word_t f, input vfl_word_t f0,
                                      input vfl_word_t f1, input vfl_word_t v0,
                                      input vfl_word_t v1);
      logic [31:0] p;
      p = 32'(v1 - v0) * 32'(f - f0);
      if (f1 <= f0 || f <= f0) return v0;
      if (f >= f1) return v1;
      return v0 + 16'(p / 32'(f1 - f0));
   endfunction : lerp

   // Converter code above an offset scaled onto zero to maximum
   function automatic vfl_word_t scale(input logic [11:0] c, input logic [11:0] ofs,
                                       input logic [31:0] span, input vfl_word_t fm);
      logic [31:0] p;
      p = 32'(c - ofs) * 32'(fm);
      if (c <= ofs) return 16'h0000;
      return minw(16'(p / span), fm);
   endfunction : scale

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [11:0] uniM_q, uniS_q, curM_q, curS_q, bipM_q, bipS_q;
   logic [1:0]  selM_q, selS_q;
   logic        encM_q, encS_q;

   // Converter codes assumed to change slowly against the clock
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {uniM_q, uniS_q, curM_q, curS_q, bipM_q, bipS_q} <= '0;
         {selM_q, selS_q, encM_q, encS_q} <= '0;
      end else begin
         {uniM_q, curM_q, bipM_q} <= {adcUni, adcCur, adcBip};
         {uniS_q, curS_q, bipS_q} <= {uniM_q, curM_q, bipM_q};
         {selM_q, encM_q} <= {accelSel, encoderCardPresent};
         {selS_q, encS_q} <= {selM_q, encM_q};
      end
   end

   // ----------------------------------------------------------------
   // Parameter store
   // ----------------------------------------------------------------
   vfl_word_t fmax_q, fbase_q, vmax_q, fmid_q, vmid_q, fmin_q, vmin_q;
   vfl_word_t upPct_q, loPct_q, dcmd_q;
   logic [1:0] meth_q, src_q;
   logic [2:0] fsel_q;

   wire        wrAcc  = psel && penable && pwrite;
   wire        setup  = psel && !penable;
   wire        isTime = (paddr >= `VFL_OFF_TIME0) && (paddr <= `VFL_OFF_TIME7)
                        && (paddr[1:0] == 2'b00);
   wire        mapped = isTime || ((paddr <= `VFL_OFF_VOUT) && (paddr[1:0] == 2'b00));
   wire [31:0] wd     = pwdata;

   // Writes clamp to the legal range instead of being refused
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fmax_q  <= `VFL_FMAX_RST;
         fbase_q <= `VFL_FBASE_RST;
         vmax_q  <= VMAX_RST;
         fmid_q  <= `VFL_FMID_RST;
         vmid_q  <= VLOW_RST;
         fmin_q  <= `VFL_FMIN_RST;
         vmin_q  <= VLOW_RST;
         upPct_q <= `VFL_UP_RST;
         loPct_q <= `VFL_LO_RST;
         {meth_q, fsel_q, src_q} <= '0;
         dcmd_q  <= 16'h0000;
      end else if (wrAcc) begin
         unique case (paddr)
            `VFL_OFF_FMAX:  fmax_q  <= clampw(wd, `VFL_FMAX_MIN, `VFL_FMAX_MAX);
            `VFL_OFF_FBASE: fbase_q <= clampw(wd, `VFL_F_MIN, `VFL_F_MAX);
            `VFL_OFF_VMAX:  vmax_q  <= clampw(wd, `VFL_V_MIN, VLIM);
            `VFL_OFF_FMID:  fmid_q  <= clampw(wd, `VFL_F_MIN, `VFL_F_MAX);
            `VFL_OFF_VMID:  vmid_q  <= clampw(wd, `VFL_V_MIN, VLIM);
            `VFL_OFF_FMIN:  fmin_q  <= clampw(wd, `VFL_F_MIN, `VFL_F_MAX);
            `VFL_OFF_VMIN:  vmin_q  <= clampw(wd, `VFL_V_MIN, VLIM);
            `VFL_OFF_UPPCT: upPct_q <= clampw(wd, `VFL_UP_MIN, `VFL_UP_MAX);
            `VFL_OFF_LOPCT: loPct_q <= clampw(wd, 16'd0, `VFL_LO_MAX);
            `VFL_OFF_CTRL: begin
               meth_q <= wd[`VFL_CTRL_METH_LSB +: 2];
               fsel_q <= wd[`VFL_CTRL_FSEL_LSB +: 3];
               src_q  <= wd[`VFL_CTRL_SRC_LSB +: 2];
            end
            `VFL_OFF_DCMD:  dcmd_q  <= wd[15:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Effective curve points: ordering enforced where they are used
   // ----------------------------------------------------------------
   wire vfl_word_t fmidE = minw(fmid_q, fbase_q);
   wire vfl_word_t fminE = minw(fmin_q, fmidE);
   wire vfl_word_t vmidE = minw(vmid_q, vmax_q);
   wire vfl_word_t vminE = minw(vmin_q, vmidE);
   wire vfl_word_t loPctE = minw(loPct_q, upPct_q);
   wire cfgBad = (fmid_q > fbase_q) || (fmin_q > fmid_q) ||
                 (vmid_q > vmax_q) || (vmin_q > vmid_q) || (loPct_q > upPct_q);

   // Method decode and mid-point bypass
   assign vectorMode        = meth_q[1];
   assign encoderFeedbackEn = (meth_q == 2'h3) && encS_q;
   wire   encMissing        = (meth_q == 2'h3) && !encS_q;
   wire   midOff            = (fsel_q >= 3'd1) && (fsel_q <= 3'd4);

   // ----------------------------------------------------------------
   // Command source and limits
   // ----------------------------------------------------------------
   wire [31:0] upProd  = 32'(fmax_q) * 32'(upPct_q);
   wire [31:0] loProd  = 32'(fmax_q) * 32'(loPctE);
   wire vfl_word_t upLim = 16'(upProd / `VFL_PCT_DIV);
   wire vfl_word_t loLim = 16'(loProd / `VFL_PCT_DIV);
   vfl_word_t cmdF;

   // Each analog source spans zero to maximum frequency
   always_comb begin
      unique case (vfl_src_t'(src_q))
         VFL_SRC_DIG: cmdF = dcmd_q;
         VFL_SRC_UNI: cmdF = scale(uniS_q, 12'h000, `VFL_ADC_FULL, fmax_q);
         VFL_SRC_CUR: cmdF = scale(curS_q, `VFL_CUR_4MA, `VFL_CUR_SPAN, fmax_q);
         VFL_SRC_BIP: cmdF = scale(bipS_q ^ `VFL_BIP_OFS, 12'h000,
                                   `VFL_ADC_FULL, fmax_q);
      endcase
   end

   // Below minimum frequency the output stops
   wire vfl_word_t target =
        (cmdF > upLim) ? upLim :
        (cmdF < fminE) ? 16'h0000 :
        (cmdF < loLim) ? loLim : cmdF;

   // ----------------------------------------------------------------
   // Ramp toward the limited target
   // ----------------------------------------------------------------
   vfl_mem_if mem ();
   vfl_ramp_t  ramp_q, ramp_d;
   vfl_word_t  fOut_q;
   logic [35:0] accum_q;

   vfl_time_mem u_time_mem (
      .core_clk (core_clk),
      .rst      (rst),
      .bus      (mem.mem)
   );

   assign mem.wrEn    = wrAcc && isTime;
   assign mem.wrAddr  = paddr[4:2];
   assign mem.wrData  = clampw(wd, `VFL_T_MIN, `VFL_T_MAX);
   assign mem.rdAddrA = paddr[4:2];
   assign mem.rdAddrB = {selS_q, ramp_q == VFL_DECEL};

   // Time word counts 0.1 s units needed to sweep the full range
   wire [35:0] thr    = 36'(mem.rdDataB) * `VFL_CYC_PER_UNIT;
   wire [35:0] accSum = accum_q + 36'(fmax_q);
   wire        step   = (ramp_q != VFL_HOLD) && (accSum >= thr);

   always_comb begin
      if (target > fOut_q) ramp_d = VFL_ACCEL;
      else if (target < fOut_q) ramp_d = VFL_DECEL;
      else ramp_d = VFL_HOLD;
   end

   // One 0.01 Hz step whenever the rate accumulator passes the time
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ramp_q  <= VFL_HOLD;
         fOut_q  <= 16'h0000;
         accum_q <= 36'h0;
      end else begin
         ramp_q  <= ramp_d;
         accum_q <= (ramp_d != ramp_q) ? 36'h0 : step ? accSum - thr : accSum;
         if (step && ramp_q == VFL_ACCEL && ramp_d == VFL_ACCEL) fOut_q <= fOut_q + 16'd1;
         if (step && ramp_q == VFL_DECEL && ramp_d == VFL_DECEL) fOut_q <= fOut_q - 16'd1;
      end
   end
   assign freqOut = fOut_q;

   // ----------------------------------------------------------------
   // Volts-per-hertz curve on the limited, ramped frequency
   // ----------------------------------------------------------------
   vfl_word_t vCurve;
   always_comb begin
      if (fOut_q == 16'h0000) vCurve = 16'h0000;
      else if (vectorMode) vCurve = lerp(fOut_q, 16'h0000, fbase_q, 16'h0000, vmax_q);
      else if (fOut_q >= fbase_q) vCurve = vmax_q;
      else if (fOut_q <= fminE) vCurve = vminE;
      else if (midOff) vCurve = lerp(fOut_q, fminE, fbase_q, vminE, vmax_q);
      else if (fOut_q < fmidE) vCurve = lerp(fOut_q, fminE, fmidE, vminE, vmidE);
      else vCurve = lerp(fOut_q, fmidE, fbase_q, vmidE, vmax_q);
   end

   // Registered so voltage trails frequency by exactly one cycle
   vfl_word_t vOut_q;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) vOut_q <= 16'h0000;
      else vOut_q <= vCurve;
   end
   assign voltOut = vOut_q;

   // ----------------------------------------------------------------
   // APB read path: zero wait, data captured in the setup cycle
   // ----------------------------------------------------------------
   logic [31:0] rdReg_q;
   logic        rdTime_q;
   vfl_word_t   rdMux;

   always_comb begin
      unique case (paddr)
         `VFL_OFF_FMAX:  rdMux = fmax_q;
         `VFL_OFF_FBASE: rdMux = fbase_q;
         `VFL_OFF_VMAX:  rdMux = vmax_q;
         `VFL_OFF_FMID:  rdMux = fmid_q;
         `VFL_OFF_VMID:  rdMux = vmid_q;
         `VFL_OFF_FMIN:  rdMux = fmin_q;
         `VFL_OFF_VMIN:  rdMux = vmin_q;
         `VFL_OFF_UPPCT: rdMux = upPct_q;
         `VFL_OFF_LOPCT: rdMux = loPct_q;
         `VFL_OFF_CTRL:  rdMux = {6'h00, src_q, 1'b0, fsel_q, 2'h0, meth_q};
         `VFL_OFF_DCMD:  rdMux = dcmd_q;
         `VFL_OFF_STAT:  rdMux = {11'h000, encMissing, cfgBad, ramp_q};
         `VFL_OFF_FOUT:  rdMux = fOut_q;
         `VFL_OFF_VOUT:  rdMux = vOut_q;
         default:        rdMux = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdReg_q  <= 32'h0;
         rdTime_q <= 1'b0;
      end else if (setup) begin
         rdReg_q  <= {16'h0000, rdMux};
         rdTime_q <= isTime;
      end
   end

   // Both sources are flip-flops; the time store answers from its port A
   assign prdata  = rdTime_q ? {16'h0000, mem.rdDataA} : rdReg_q;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_fmax_range;
      @(posedge core_clk) disable iff (rst)
      (fmax_q >= `VFL_FMAX_MIN) && (fmax_q <= `VFL_FMAX_MAX);
   endproperty
   a_fmax_range: assert property (p_fmax_range) else $error("max freq out of range");

   property p_upper;
      @(posedge core_clk) disable iff (rst) target <= upLim;
   endproperty
   a_upper: assert property (p_upper) else $error("target above upper limit");

   property p_lower;
      @(posedge core_clk) disable iff (rst)
      (cmdF >= fminE && cmdF < loLim && loLim <= upLim) |-> target == loLim;
   endproperty
   a_lower: assert property (p_lower) else $error("lower limit not applied");

   property p_pct_order;
      @(posedge core_clk) disable iff (rst) loLim <= upLim;
   endproperty
   a_pct_order: assert property (p_pct_order) else $error("lower above upper");

   property p_curve_order;
      @(posedge core_clk) disable iff (rst)
      fminE <= fmidE && fmidE <= fbase_q && vminE <= vmidE && vmidE <= vmax_q;
   endproperty
   a_curve_order: assert property (p_curve_order) else $error("curve order broken");

   property p_above_base;
      @(posedge core_clk) disable iff (rst)
      (fOut_q >= fbase_q && fOut_q != 16'h0000 && !vectorMode) |=> voltOut == $past(vmax_q);
   endproperty
   a_above_base: assert property (p_above_base) else $error("not max volts");

   property p_vector_lin;
      @(posedge core_clk) disable iff (rst)
      (vectorMode && fOut_q != 16'h0000 && fOut_q < fbase_q) |=> voltOut < $past(vmax_q);
   endproperty
   a_vector_lin: assert property (p_vector_lin) else $error("vector volts wrong");

   property p_ramp_step;
      @(posedge core_clk) disable iff (rst)
      ##1 (fOut_q == $past(fOut_q) || fOut_q == $past(fOut_q) + 16'd1 ||
           fOut_q == $past(fOut_q) - 16'd1);
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("ramp jumped");

   property p_vmax_lim;
      @(posedge core_clk) disable iff (rst) vmax_q <= VLIM && voltOut <= VLIM;
   endproperty
   a_vmax_lim: assert property (p_vmax_lim) else $error("voltage above series limit");
endmodule : vfl_limiter

//--- vfl_limiter_bench.sv
// Self-checking bench for the limiter: APB set-up, clamping, ramp and curve.
// Assumes vfl_limiter with zero-wait APB and a 10 MHz core clock.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %0h want %0h", $time, (a), (e)); end end
module vfl_limiter_bench;
   import vfl_pkg::*;
   logic               core_clk = 1'b0;
   logic               rst = 1'b1;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic               cardIn = 1'b0;
   logic [11:0]        adcU = 12'h000;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0;
   logic [31:0]        prdata, rdVal;
   logic               pready, pslverr, errVal, vectorMode, encFb;
   vfl_word_t          freqOut, voltOut;
   int                 failures = 0;
   int                 total_checks = 0;
   int                 cyc;
   // ----------------------------------------------------------------
   // Clock, device
   // ----------------------------------------------------------------
   always #50 core_clk = ~core_clk;
   // Current and bipolar pins and set select tied; the unipolar pin is driven
   vfl_limiter dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .adcUni(adcU), .adcCur(12'h000),
      .adcBip(12'h000), .accelSel(2'h0), .encoderCardPresent(cardIn),
      .freqOut(freqOut), .voltOut(voltOut), .vectorMode(vectorMode),
      .encoderFeedbackEn(encFb));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task conclude;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   // One APB transfer; the wait for pready is bounded
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdVal = prdata;
      errVal = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         failures++;
         conclude();
      end
   endtask : apb
   // Ramps are slow, so the wait is long but still bounded
   task automatic waitFreq(input vfl_word_t t);
      cyc = 0;
      while (freqOut !== t && cyc < 40000) begin
         @(posedge core_clk);
         cyc++;
      end
      if (cyc >= 40000) begin
         failures++;
         conclude();
      end
   endtask : waitFreq
   task automatic tResetVals;
      logic [7:0] ad[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                             8'h1c, 8'h20, 8'h40};
      logic [15:0] ex[10] = '{16'd6000, 16'd6000, 16'd2200, 16'd50, 16'd17, 16'd50,
                              16'd17, 16'd100, 16'd0, 16'd100};
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, ad[i], 32'h0);
         `CHK(rdVal, {16'h0, ex[i]})
      end
   endtask : tResetVals
   // Out-of-range settings clamp; an unmapped place answers with an error
   task automatic tRanges;
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdVal, 32'd5000)
      apb(1'b1, 8'h1c, 32'd200);
      apb(1'b0, 8'h1c, 32'h0);
      `CHK(rdVal, 32'd120)
      apb(1'b0, 8'h38, 32'h0);
      `CHK({errVal, rdVal}, 33'h100000000)
   endtask : tRanges
   task automatic tMethod;
      apb(1'b1, 8'h24, 32'h2);
      // The write lands at the edge the task returns on; look once it settles
      @(negedge core_clk);
      `CHK({vectorMode, encFb}, 2'b10)
      cardIn <= 1'b1;
      apb(1'b1, 8'h24, 32'h3);
      repeat (5) @(posedge core_clk);
      `CHK({vectorMode, encFb}, 2'b11)
      apb(1'b1, 8'h24, 32'h0);
   endtask : tMethod
   // Command between minimum and lower limit; base kept low so voltage tops out
   task automatic tLower;
      apb(1'b1, 8'h04, 32'd10);
      apb(1'b1, 8'h1c, 32'd100);
      apb(1'b1, 8'h20, 32'd2);
      apb(1'b1, 8'h40, 32'd1);
      apb(1'b1, 8'h44, 32'd1);
      apb(1'b1, 8'h28, 32'd55);
      waitFreq(16'd100);
      `CHK(cyc > 19000 && cyc < 21000, 1'b1)
      repeat (500) @(posedge core_clk);
      `CHK(freqOut, 16'd100)
      `CHK(voltOut, 16'd2200)
   endtask : tLower
   // Upper below lower percentage: command clamps down to upper limit
   task automatic tUpper;
      apb(1'b1, 8'h1c, 32'd1);
      waitFreq(16'd50);
      repeat (500) @(posedge core_clk);
      apb(1'b0, 8'h30, 32'h0);
      `CHK(rdVal, 32'd50)
      `CHK(voltOut, 16'd2200)
   endtask : tUpper
   // Output held at 0.50 Hz: three-point, two-point and vector curve shapes
   task automatic tCurve;
      apb(1'b1, 8'h04, 32'd100);
      apb(1'b1, 8'h14, 32'd10);
      apb(1'b1, 8'h0c, 32'd30);
      apb(1'b1, 8'h10, 32'd1000);
      repeat (3) @(posedge core_clk);
      `CHK(voltOut, 16'd1342)
      apb(1'b1, 8'h24, 32'h10);
      repeat (3) @(posedge core_clk);
      `CHK(voltOut, 16'd987)
      apb(1'b1, 8'h24, 32'h2);
      repeat (3) @(posedge core_clk);
      `CHK(voltOut, 16'd1100)
   endtask : tCurve
   // Unipolar code 45 of 4095 on a 50.00 Hz range commands 0.54 Hz
   task automatic tAnalog;
      adcU <= 12'd45;
      apb(1'b1, 8'h1c, 32'd100);
      apb(1'b1, 8'h20, 32'd0);
      apb(1'b1, 8'h24, 32'h100);
      waitFreq(16'd54);
      repeat (500) @(posedge core_clk);
      `CHK(freqOut, 16'd54)
      `CHK(voltOut, 16'd1411)
   endtask : tAnalog
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      `CHK({freqOut, voltOut}, 32'h0)
      tResetVals();
      tRanges();
      tMethod();
      tLower();
      tUpper();
      tCurve();
      tAnalog();
      conclude();
   end
endmodule : vfl_limiter_bench
